// *** rtl/tbi_pkg.sv ***
// Functional notes
// R1: Each buffer opens with command A, then B.
// R2: Packet bounds come only from command bits.
// R3: Copy 16-bit tag into packet status word.
// R4: Differing tags within one packet raise error.
// R5: Count payload bytes; mismatch with length errors.
// R6: Payload starts at offset inside first 8 words.
// R7: Following buffers start anywhere, joined without gaps.
// R8: Accept trailing pad words, drop them before sending.
// R9: Completion request signals event after buffer loaded.
// R10: One status word per packet into status FIFO.
// R11: Optional level signal on waiting status words.
// R12: Host writes no more than reported free space.
// R13: Host overfilling the data FIFO raises error.
// R14: Commands A and B are 32-bit, both required.
// R15: Command B differing within a packet raises error.
// R16: Alignment bits 25:24 select 4, 16, 32 bytes.
// R17: Command A bit 31 requests buffer-done flag.
// R18: Error flag stays set until software clears it.
package tbi_pkg;
   // ==========================================================
   // Register map, byte addresses on the AXI4-Lite slave
   localparam logic [7:0] TBI_ADDR_DATA   = 8'h00;
   localparam logic [7:0] TBI_ADDR_STATUS = 8'h04;
   localparam logic [7:0] TBI_ADDR_INFO   = 8'h08;
   localparam logic [7:0] TBI_ADDR_FLAGS  = 8'h0C;
   localparam logic [7:0] TBI_ADDR_CFG    = 8'h10;
   // Flag bit positions and reset values
   localparam int         TBI_FLAG_ERR     = 0;
   localparam int         TBI_FLAG_DONE    = 1;
   localparam int         TBI_FLAG_LEVEL   = 2;
   localparam int         TBI_CFG_LVL_EN   = 8;
   localparam logic [8:0] TBI_CFG_RESET    = 9'h000;
   localparam logic [1:0] TBI_RESP_OKAY    = 2'b00;
   localparam logic [1:0] TBI_RESP_SLVERR  = 2'b10;
   // End alignment codes and their size in words
   localparam logic [1:0] TBI_ALIGN_4      = 2'b00;
   localparam logic [1:0] TBI_ALIGN_16     = 2'b01;
   localparam logic [1:0] TBI_ALIGN_32     = 2'b10;
   localparam logic [9:0] TBI_WORDS_4      = 10'h001;
   localparam logic [9:0] TBI_WORDS_16     = 10'h004;
   localparam logic [9:0] TBI_WORDS_32     = 10'h008;
   localparam logic [11:0] TBI_ROUND_UP    = 12'h003;

   // ==========================================================
   // Command and status layouts
   typedef struct packed {
      logic        done_req;    // 31
      logic [4:0]  rsvd_a;      // 30:26
      logic [1:0]  end_align;   // 25:24
      logic [2:0]  rsvd_b;      // 23:21
      logic [4:0]  start_off;   // 20:16
      logic [1:0]  rsvd_c;      // 15:14
      logic        first_seg;   // 13
      logic        last_seg;    // 12
      logic        rsvd_d;      // 11
      logic [10:0] buf_size;    // 10:0
   } tbi_cmd_a_t;

   typedef struct packed {
      logic [15:0] pkt_tag;
      logic [4:0]  rsvd;
      logic [10:0] pkt_len;
   } tbi_cmd_b_t;

   typedef struct packed {
      logic [15:0] pkt_tag;
      logic        pkt_err;
      logic [3:0]  rsvd;
      logic [10:0] pkt_len;
   } tbi_status_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  byte_en;
      logic        pkt_last;
   } tbi_word_t;

   // Gray order along the usual path
   typedef enum logic [1:0] {
      TBI_ST_CMD_A = 2'b00,
      TBI_ST_CMD_B = 2'b01,
      TBI_ST_DATA  = 2'b11,
      TBI_ST_PAD   = 2'b10
   } tbi_state_t;
endpackage : tbi_pkg

// *** rtl/tbi_buf.sv ***
`timescale 1ns/10ps
// ==========================================================
// Small ready/valid buffer, flip-flop storage
module tbi_buf
   import tbi_pkg::*;
#(
   parameter int WIDTH = 37,
   parameter int DEPTH = 2
)(
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // Fill side
   input  wire logic                       in_valid,
   output      logic                       in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   // Drain side
   output      logic                       out_valid,
   input  wire logic                       out_ready,
   output      logic [WIDTH-1:0]           out_data,
   // Occupancy
   output      logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [$clog2(DEPTH+1)-1:0] FULL = ($clog2(DEPTH+1))'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic             push;
   logic             pop;

   // Honest full and empty from the count
   assign in_ready  = (count != FULL);
   assign out_valid = (count != '0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage
   always_ff @(posedge aclk)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and count; wrap assumes a power-of-two depth
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count      <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
         end
         if (pop)
         begin
            rd_ptr_reg <= PW'(rd_ptr_reg + 1'b1);
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : tbi_buf

// *** rtl/tbi_intake.sv ***
`timescale 1ns/10ps
// ==========================================================
// Transmit command and payload intake behind AXI4-Lite
module tbi_intake
   import tbi_pkg::*;
#(
   parameter int DATA_DEPTH = 2,
   parameter int STS_DEPTH  = 4
)(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output      logic [1:0]  s_axi_bresp,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   // Payload toward the transmitter
   output      logic        tx_out_valid,
   input  wire logic        tx_out_ready,
   output      tbi_word_t   tx_out_word,
   // Event outputs
   output      logic        buffer_done_flag,
   output      logic        transmit_error_flag,
   output      logic        status_level_irq
);
   localparam int SPW = $clog2(STS_DEPTH);
   localparam int SCW = $clog2(STS_DEPTH+1);
   localparam int DCW = $clog2(DATA_DEPTH+1);
   localparam logic [SCW-1:0] STS_FULL = SCW'(STS_DEPTH);
   localparam logic [15:0]    DATA_CAP = 16'(DATA_DEPTH);

   // ==========================================================
   // Bus slave state
   logic [7:0]  awaddr_reg;
   logic        aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        w_held_reg;
   logic        wr_fire;
   logic        rd_fire;
   logic        word_valid;
   logic        clr_err;
   logic        clr_done;

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp   = TBI_RESP_OKAY;
   // Write runs once address and data are both in and the response slot is free
   assign wr_fire    = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign rd_fire    = s_axi_arvalid && s_axi_arready;
   assign word_valid = wr_fire && (awaddr_reg == TBI_ADDR_DATA);
   assign clr_err    = wr_fire && (awaddr_reg == TBI_ADDR_FLAGS) && wdata_reg[TBI_FLAG_ERR];
   assign clr_done   = wr_fire && (awaddr_reg == TBI_ADDR_FLAGS) && wdata_reg[TBI_FLAG_DONE];

   // Address and data latches, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         else if (wr_fire)
         begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         else if (wr_fire)
         begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Configuration register
   logic [8:0] cfg_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_reg <= TBI_CFG_RESET;
      end
      else if (wr_fire && (awaddr_reg == TBI_ADDR_CFG))
      begin
         if (wstrb_reg[0])
         begin
            cfg_reg[7:0] <= wdata_reg[7:0];
         end
         if (wstrb_reg[1])
         begin
            cfg_reg[TBI_CFG_LVL_EN] <= wdata_reg[TBI_CFG_LVL_EN];
         end
      end
   end

   // Write response; unmapped offsets and the read-only ones answer SLVERR
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= TBI_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         if ((awaddr_reg == TBI_ADDR_DATA) || (awaddr_reg == TBI_ADDR_FLAGS) || (awaddr_reg == TBI_ADDR_CFG))
         begin
            s_axi_bresp <= TBI_RESP_OKAY;
         end
         else
         begin
            s_axi_bresp <= TBI_RESP_SLVERR;
         end
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Command parser
   tbi_state_t  state_reg;
   tbi_cmd_a_t  cmd_a_reg;
   tbi_cmd_b_t  pkt_b_reg;
   tbi_cmd_b_t  word_b;
   tbi_cmd_b_t  ref_b;
   logic [9:0]  widx_reg;
   logic [11:0] pkt_bytes_reg;
   logic        pkt_err_reg;
   logic [11:0] span;
   logic [9:0]  need;
   logic [9:0]  align_w;
   logic [9:0]  padded;
   logic [11:0] pos;
   logic [11:0] lim;
   logic [3:0]  be_c;
   logic [2:0]  nbytes;
   logic        data_word;
   logic        buf_end;
   logic        pkt_end;
   logic        push_out;
   logic        in_ready;
   logic        overflow;
   logic        b_mismatch;
   logic        tag_mismatch;
   logic        len_err;
   logic [11:0] bytes_total;

   assign word_b = tbi_cmd_b_t'(wdata_reg);
   assign span   = 12'({7'h00, cmd_a_reg.start_off}) + 12'({1'b0, cmd_a_reg.buf_size}) + TBI_ROUND_UP;
   assign need   = span[11:2];
   // Whole-word count padded up to the chosen end boundary [R16]
   always_comb
   begin
      case (cmd_a_reg.end_align)
         TBI_ALIGN_16: align_w = TBI_WORDS_16;
         TBI_ALIGN_32: align_w = TBI_WORDS_32;
         default:      align_w = TBI_WORDS_4;
      endcase
   end
   assign padded = (need + align_w - 1'b1) & ~(align_w - 1'b1); // [R8]

   // Byte lanes inside the offset..offset+size window are payload [R6] [R7]
   always_comb
   begin
      be_c   = '0;
      nbytes = '0;
      pos    = '0;
      lim    = 12'({7'h00, cmd_a_reg.start_off}) + 12'({1'b0, cmd_a_reg.buf_size});
      for (int k = 0; k < 4; k++)
      begin
         pos = {widx_reg, 2'(k)};
         if ((pos >= 12'({7'h00, cmd_a_reg.start_off})) && (pos < lim))
         begin
            be_c[k] = 1'b1;
            nbytes  = nbytes + 1'b1;
         end
      end
   end

   assign data_word    = word_valid && (state_reg == TBI_ST_DATA);
   assign buf_end      = (word_valid && (state_reg == TBI_ST_CMD_B) && (padded == '0))
                      || (word_valid && (state_reg != TBI_ST_CMD_A) && (state_reg != TBI_ST_CMD_B)
                          && (widx_reg == padded - 1'b1));
   assign pkt_end      = buf_end && cmd_a_reg.last_seg; // [R2]
   assign push_out     = data_word && (be_c != '0);
   assign overflow     = push_out && !in_ready; // [R13]
   assign b_mismatch   = word_valid && (state_reg == TBI_ST_CMD_B) && !cmd_a_reg.first_seg && (word_b != pkt_b_reg);
   assign tag_mismatch = b_mismatch && (word_b.pkt_tag != pkt_b_reg.pkt_tag); // [R4]
   assign ref_b        = (state_reg == TBI_ST_CMD_B) && cmd_a_reg.first_seg ? word_b : pkt_b_reg;
   assign bytes_total  = pkt_bytes_reg + (push_out ? 12'({9'h000, nbytes}) : 12'h000);
   assign len_err      = bytes_total != 12'({1'b0, ref_b.pkt_len}); // [R5]

   // Sequence: command A, command B, payload, padding [R1] [R14]
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= TBI_ST_CMD_A;
         cmd_a_reg <= '0;
         widx_reg  <= '0;
      end
      else if (word_valid)
      begin
         case (state_reg)
            TBI_ST_CMD_A:
            begin
               cmd_a_reg <= tbi_cmd_a_t'(wdata_reg);
               state_reg <= TBI_ST_CMD_B;
            end
            TBI_ST_CMD_B:
            begin
               widx_reg  <= '0;
               state_reg <= (padded == '0) ? TBI_ST_CMD_A : (need == '0) ? TBI_ST_PAD : TBI_ST_DATA;
            end
            default:
            begin
               widx_reg <= widx_reg + 1'b1;
               if (buf_end)
               begin
                  state_reg <= TBI_ST_CMD_A;
               end
               else if (widx_reg == need - 1'b1)
               begin
                  state_reg <= TBI_ST_PAD; // Trailing pad words are swallowed
               end
            end
         endcase
      end
   end

   // Per-packet reference command B, byte count and error
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pkt_b_reg     <= '0;
         pkt_bytes_reg <= '0;
         pkt_err_reg   <= 1'b0;
      end
      else
      begin
         if (word_valid && (state_reg == TBI_ST_CMD_B) && cmd_a_reg.first_seg)
         begin
            pkt_b_reg <= word_b; // [R15]
         end
         if (pkt_end)
         begin
            pkt_bytes_reg <= '0;
            pkt_err_reg   <= 1'b0;
         end
         else
         begin
            pkt_bytes_reg <= bytes_total;
            pkt_err_reg   <= pkt_err_reg | b_mismatch | overflow;
         end
      end
   end

   // ==========================================================
   // Two-entry payload buffer; a stalled receiver shows as lost free space
   tbi_word_t  buf_in;
   logic [DCW-1:0] data_count;

   // Marker rides on the last payload word; trailing pad words never reach the buffer
   assign buf_in = '{data: wdata_reg, byte_en: be_c,
                     pkt_last: cmd_a_reg.last_seg && (widx_reg == need - 1'b1)}; // [R2]

   tbi_buf #(
      .WIDTH ($bits(tbi_word_t)),
      .DEPTH (DATA_DEPTH)
   ) u_data_buf (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (push_out),
      .in_ready  (in_ready),
      .in_data   (buf_in),
      .out_valid (tx_out_valid),
      .out_ready (tx_out_ready),
      .out_data  (tx_out_word),
      .count     (data_count)
   );

   // ==========================================================
   // Status FIFO, one word per packet
   tbi_status_t sts_mem_reg [STS_DEPTH];
   logic [SPW-1:0] sts_wr_reg;
   logic [SPW-1:0] sts_rd_reg;
   logic [SCW-1:0] sts_count_reg;
   logic           sts_push;
   logic           sts_pop;
   logic           sts_drop;

   assign sts_pop  = rd_fire && (s_axi_araddr == TBI_ADDR_STATUS) && (sts_count_reg != '0);
   assign sts_push = pkt_end && (sts_count_reg != STS_FULL);
   assign sts_drop = pkt_end && (sts_count_reg == STS_FULL);

   // Tag is copied untouched into the status word [R3] [R10]
   always_ff @(posedge aclk)
   begin
      if (sts_push)
      begin
         sts_mem_reg[sts_wr_reg] <= '{pkt_tag: ref_b.pkt_tag, pkt_err: pkt_err_reg | b_mismatch | overflow | len_err,
                                     rsvd: '0, pkt_len: ref_b.pkt_len};
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sts_wr_reg    <= '0;
         sts_rd_reg    <= '0;
         sts_count_reg <= '0;
      end
      else
      begin
         if (sts_push)
         begin
            sts_wr_reg <= SPW'(sts_wr_reg + 1'b1);
         end
         if (sts_pop)
         begin
            sts_rd_reg <= SPW'(sts_rd_reg + 1'b1);
         end
         if (sts_push && !sts_pop)
         begin
            sts_count_reg <= sts_count_reg + 1'b1;
         end
         else if (sts_pop && !sts_push)
         begin
            sts_count_reg <= sts_count_reg - 1'b1;
         end
      end
   end

   // ==========================================================
   // Sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         transmit_error_flag <= 1'b0;
         buffer_done_flag    <= 1'b0;
      end
      else
      begin
         transmit_error_flag <= b_mismatch | overflow | (pkt_end && len_err) | sts_drop
                             | (transmit_error_flag && !clr_err); // [R18]
         buffer_done_flag    <= (buf_end && cmd_a_reg.done_req) | (buffer_done_flag && !clr_done); // [R9] [R17]
      end
   end

   // Level output on waiting status words [R11]
   assign status_level_irq = cfg_reg[TBI_CFG_LVL_EN] && (cfg_reg[7:0] != '0)
                          && (8'(sts_count_reg) >= cfg_reg[7:0]);

   // Read data; the status port pops one word per read
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         if (s_axi_araddr == TBI_ADDR_STATUS)
         begin
            s_axi_rdata <= (sts_count_reg != '0) ? sts_mem_reg[sts_rd_reg] : '0;
         end
         else if (s_axi_araddr == TBI_ADDR_INFO)
         begin
            s_axi_rdata <= {8'h00, 8'(sts_count_reg), DATA_CAP - 16'(data_count)}; // Free space for the host
         end
         else if (s_axi_araddr == TBI_ADDR_FLAGS)
         begin
            s_axi_rdata <= {29'h0000_0000, status_level_irq, buffer_done_flag, transmit_error_flag};
         end
         else if (s_axi_araddr == TBI_ADDR_CFG)
         begin
            s_axi_rdata <= {23'h00_0000, cfg_reg};
         end
         else
         begin
            s_axi_rdata <= '0;
         end
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_order; word_valid && (state_reg == TBI_ST_CMD_A) |=> (state_reg == TBI_ST_CMD_B); endproperty
   a_order: assert property (p_order) else $error("command B must follow command A"); // [R1]
   property p_cmdb; word_valid && (state_reg == TBI_ST_CMD_B) |=> (state_reg != TBI_ST_CMD_B); endproperty
   a_cmdb: assert property (p_cmdb) else $error("command B held longer than one word"); // [R14]
   property p_tag; tag_mismatch |=> transmit_error_flag; endproperty
   a_tag: assert property (p_tag) else $error("tag mismatch did not raise error"); // [R4]
   property p_cmdb_err; b_mismatch |=> transmit_error_flag; endproperty
   a_cmdb_err: assert property (p_cmdb_err) else $error("command B mismatch did not raise error"); // [R15]
   property p_ovf; overflow |=> transmit_error_flag; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow did not raise error"); // [R13]
   property p_sticky; transmit_error_flag && !clr_err |=> transmit_error_flag; endproperty
   a_sticky: assert property (p_sticky) else $error("error flag dropped without clear"); // [R18]
   property p_done; buf_end && cmd_a_reg.done_req |=> buffer_done_flag; endproperty
   a_done: assert property (p_done) else $error("buffer done not flagged"); // [R17]
   property p_pad; (state_reg == TBI_ST_PAD) |-> !push_out; endproperty
   a_pad: assert property (p_pad) else $error("pad word reached payload"); // [R8]
   property p_sts; pkt_end && !sts_drop && !sts_pop |=> (sts_count_reg == $past(sts_count_reg) + 1'b1); endproperty
   a_sts: assert property (p_sts) else $error("status word not queued"); // [R10]
   property p_len; pkt_end && len_err |=> transmit_error_flag; endproperty
   a_len: assert property (p_len) else $error("length mismatch did not raise error"); // [R5]
endmodule : tbi_intake

// *** verification/tbi_sink.sv ***
`timescale 1ns/10ps
// ==========================================================
// Receiver model, takes a word at most three cycles in four
module tbi_sink
   import tbi_pkg::*;
(
   // Clock and reset
   input  wire logic      aclk,
   input  wire logic      aresetn,
   // Payload stream
   input  wire logic      tx_out_valid,
   output      logic      tx_out_ready,
   input  wire tbi_word_t tx_out_word,
   // Hold off completely
   input  wire logic      stall
);
   tbi_word_t  got[$];
   logic [1:0] cyc_reg;
   // Ready changes only after an edge, so a stall never cuts a word
   always_ff @(posedge aclk)
   begin
      cyc_reg <= aresetn ? cyc_reg + 2'd1 : 2'd0;
      tx_out_ready <= aresetn && !stall && cyc_reg != 2'd0;
      if (tx_out_valid && tx_out_ready)
         got.push_back(tx_out_word);
   end
endmodule : tbi_sink

// *** verification/tx_buffer_command_intake_test.sv ***
`timescale 1ns/10ps
// ==========================================================
// Bench for the transmit intake
module tx_buffer_command_intake_test;
   import tbi_pkg::*;
   logic        aclk, aresetn, stall, tx_out_valid, tx_out_ready;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        buffer_done_flag, transmit_error_flag, status_level_irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   tbi_word_t   tx_out_word;
   int          n_mismatch, n_compared, k;
   int          nw[4] = '{1, 4, 8, 1};
   logic [31:0] b1[4] = '{32'h0007_0008, 32'h0007_0008, 32'h0007_0008, 32'h0007_0009};
   logic [31:0] b2[4] = '{32'h0007_0008, 32'h0008_0008, 32'h0007_0009, 32'h0007_0009};
   logic        e[4]  = '{1'b0, 1'b1, 1'b1, 1'b1};

   tbi_intake dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .tx_out_valid, .tx_out_ready, .tx_out_word, .buffer_done_flag,
      .transmit_error_flag, .status_level_irq);
   tbi_sink u_sink (.aclk, .aresetn, .tx_out_valid, .tx_out_ready, .tx_out_word, .stall);

   // Clock, 5 ns period
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 50) n_mismatch++;
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 50) n_mismatch++;
      rd_v = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic buf_send(input logic [31:0] ca, input logic [31:0] cb, input int n);
      int i;
      wr(TBI_ADDR_DATA, ca);
      wr(TBI_ADDR_DATA, cb);
      for (i = 0; i < n; i++)
         wr(TBI_ADDR_DATA, 32'h1111_1111 * (i + 1));
   endtask : buf_send

   // Next word seen by the receiver, bounded wait
   task automatic ow(input logic [3:0] be, input logic last, input int i);
      int n;
      tbi_word_t w;
      for (n = 0; n < 50 && u_sink.got.size() == 0; n++)
         @(posedge aclk);
      w = (u_sink.got.size() > 0) ? u_sink.got.pop_front() : '0;
      check("lanes", {w.byte_en, w.pkt_last}, {be, last});
      check("data", w.data, 32'h1111_1111 * i);
   endtask : ow

   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      final_report();
   end

   // Test sequence
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stall} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      aresetn = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(TBI_ADDR_INFO);
      check("info", rd_v, 32'h0000_0002);
      rd(TBI_ADDR_FLAGS);
      check("flags", rd_v, 32'h0000_0000);
      wr(8'h40, 32'h0000_0000);
      check("bresp", resp, TBI_RESP_SLVERR);
      wr(TBI_ADDR_CFG, 32'h0000_0101);
      $display("test reset done");
      // Offset 1, six bytes, completion requested
      buf_send(32'h8001_3006, 32'hABCD_0006, 2);
      ow(4'b1110, 1'b0, 1);
      ow(4'b0111, 1'b1, 2);
      check("done", buffer_done_flag, 1'b1);
      check("level", status_level_irq, 1'b1);
      rd(TBI_ADDR_FLAGS);
      check("flags", rd_v, 32'h0000_0006);
      rd(TBI_ADDR_STATUS);
      check("status", rd_v, 32'hABCD_0006);
      check("level", status_level_irq, 1'b0);
      wr(TBI_ADDR_FLAGS, 32'h0000_0003);
      $display("test offset done");
      // Every alignment code, pad words must vanish
      for (k = 0; k < 4; k++)
      begin
         buf_send({6'd0, k[1:0], 24'h00_3004}, 32'h0000_0004, nw[k]);
         ow(4'b1111, 1'b1, 1);
         rd(TBI_ADDR_STATUS);
         check("status", rd_v, 32'h0000_0004);
      end
      rd(TBI_ADDR_FLAGS);
      check("flags", rd_v, 32'h0000_0000);
      $display("test alignment done");
      // Two-buffer packets: clean, tag, command B and length faults
      for (k = 0; k < 4; k++)
      begin
         buf_send(32'h0000_2004, b1[k], 1);
         buf_send(32'h0002_1004, b2[k], 2);
         ow(4'b1111, 1'b0, 1);
         ow(4'b1100, 1'b0, 1);
         ow(4'b0011, 1'b1, 2);
         rd(TBI_ADDR_STATUS);
         check("sterr", rd_v[15], e[k]);
         rd(TBI_ADDR_FLAGS);
         check("err", rd_v[0], e[k]);
         wr(TBI_ADDR_FLAGS, 32'h0000_0003);
      end
      $display("test split done");
      // Overfill while the receiver stalls
      stall <= 1'b1;
      buf_send(32'h0000_3010, 32'h0000_0010, 4);
      rd(TBI_ADDR_INFO);
      check("free", rd_v[15:0], 16'h0000);
      check("err", transmit_error_flag, 1'b1);
      stall <= 1'b0;
      ow(4'b1111, 1'b0, 1);
      ow(4'b1111, 1'b0, 2);
      rd(TBI_ADDR_STATUS);
      check("sterr", rd_v[15], 1'b1);
      check("err", transmit_error_flag, 1'b1);
      wr(TBI_ADDR_FLAGS, 32'h0000_0003);
      rd(TBI_ADDR_FLAGS);
      check("flags", rd_v, 32'h0000_0000);
      $display("test overflow done");
      final_report();
   end
endmodule : tx_buffer_command_intake_test
